// ===== src/accum_round_saturate_shift.sv
`timescale 1ns/10ps
// Function
// RULE_01 - Catastrophic bit 39 overflow sets sticky A/B limit flag; accumulator just wraps.
// RULE_02 - With catastrophic trap enable set, such overflow raises a trap request.
// RULE_03 - Accumulate ops except plain/negated multiply and distance ops store non-target high word.
// RULE_04 - Write-back store goes over the X write bus to any data address.
// RULE_05 - Register-direct write-back puts rounded 1.15 value into the write-back pointer.
// RULE_06 - Post-increment write-back stores at pointer address, then pointer advances by 2.
// RULE_07 - Combinational rounding, conventional or convergent by round mode select bit.
// RULE_08 - Without rounding, high word passes truncated and low word is dropped.
// RULE_09 - Conventional: increment high word when low word is 0x8000 to 0xFFFF.
// RULE_10 - Convergent: low word exactly 0x8000 increments only when bit 16 is one.
// RULE_11 - Store ops write truncated or rounded target accumulator through write saturation.
// RULE_12 - Accumulate-class write-back data is always rounded, never truncated.
// RULE_13 - Write saturation alters only the stored value, never the accumulator.
// RULE_14 - Saturation uses rounded word plus accumulator and round adder overflow status.
// RULE_15 - Clamp on: post-round value above 0x007FFF is stored as 0x7FFF.
// RULE_16 - Clamp on: post-round value below 0xFF8000 is stored as 0x8000.
// RULE_17 - Sign of the tested operand is accumulator bit 39.
// RULE_18 - Clamp off: rounded or truncated value passes unmodified.
// RULE_19 - One-cycle shifter: arithmetic/logical right or left up to 16 bits.
// RULE_20 - Signed shift amount: positive right, negative left, zero unchanged.
// RULE_21 - 40-bit shifter; 40-bit accumulator result, 16-bit general result.
// RULE_22 - X operand sits at bits 16..31 for right, 0..15 for left shifts.
// RULE_23 - Core keeps round mode and clamp settings stable during stores.
module accum_round_saturate_shift (
  input  wire logic                  clk,
  input  wire logic                  srst,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [15:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [15:0]           reg_rdata,
  input  wire arss_pkg::op_req_t     op,
  input  wire logic [39:0]           acc_a,
  input  wire logic [39:0]           acc_b,
  input  wire logic                  acc_a_ovf39,
  input  wire logic                  acc_b_ovf39,
  output arss_pkg::xwrite_t          xw,
  output arss_pkg::shift_res_t       shift_res,
  output logic                       accum_a_limit_flag,
  output logic                       accum_b_limit_flag,
  output logic                       trap_req,
  output logic                       round_mode_select,
  output logic                       data_write_clamp_enable,
  output logic                       catastrophic_trap_enable,
  output logic      [15:0]           writeback_pointer_reg
);

  arss_pkg::state_t state_q;
  arss_pkg::state_t state_d;

  // Rounds and clamps one accumulator toward a 1.15 word
  function automatic logic [15:0] store_word(
    input logic [39:0] acc,
    input logic        do_round,
    input logic        convergent,
    input logic        clamp
  );
    logic [15:0] accum_high_word;
    logic [15:0] accum_low_word;
    logic        inc;
    logic [24:0] wide;
    logic [15:0] rounded;
    logic        src_ovf;
    logic        rnd_ovf;
    logic [15:0] result;
    accum_high_word = acc[31:16];
    accum_low_word  = acc[15:0];
    inc = 1'b0;
    if (do_round) begin
      inc = accum_low_word[15];                                   // see RULE_09
      if (convergent && accum_low_word == arss_pkg::LOW_HALF) begin
        inc = acc[16];                                            // see RULE_10
      end
    end
    // Truncation simply skips the increment and ignores the low word
    rounded = accum_high_word + {15'h0000, inc};                  // see RULE_07, RULE_08
    wide    = {acc[39], acc[39:16]} + {24'h000000, inc};
    // Guard bits disagreeing with bit 31, or the round adder wrapping, is overflow
    src_ovf = (acc[39:31] != {9{acc[39]}});
    rnd_ovf = inc && (accum_high_word == arss_pkg::POS_CLAMP);
    result  = rounded;
    if (clamp && (src_ovf || rnd_ovf)) begin                      // see RULE_14
      if (!acc[39] && $signed(wide) > $signed(arss_pkg::POS_LIMIT)) begin // see RULE_17
        result = arss_pkg::POS_CLAMP;                             // see RULE_15
      end else if (acc[39] && $signed(wide) < $signed(arss_pkg::NEG_LIMIT)) begin
        result = arss_pkg::NEG_CLAMP;                             // see RULE_16
      end
    end
    // Clamp off leaves result as rounded                          see RULE_18
    store_word = result;
  endfunction : store_word

  logic [39:0] target_acc;
  logic [39:0] other_acc;
  logic [15:0] store_trunc_word;
  logic [15:0] store_round_word;
  logic [15:0] wb_word;
  logic [39:0] sh_operand;
  logic [39:0] sh_out;
  logic [5:0]  sh_mag;
  logic        sh_right;

  always_comb begin
    target_acc = op.target_b ? acc_b : acc_a;
    other_acc  = op.target_b ? acc_a : acc_b;
    // Accumulator inputs are only read here, nothing is written back to them
    store_trunc_word = store_word(target_acc, 1'b0,               // see RULE_11, RULE_13
                                  state_q.ctrl[arss_pkg::CTRL_ROUND_BIT],
                                  state_q.ctrl[arss_pkg::CTRL_CLAMP_BIT]);
    store_round_word = store_word(target_acc, 1'b1,
                                  state_q.ctrl[arss_pkg::CTRL_ROUND_BIT],
                                  state_q.ctrl[arss_pkg::CTRL_CLAMP_BIT]);
    wb_word          = store_word(other_acc, 1'b1,                // see RULE_12
                                  state_q.ctrl[arss_pkg::CTRL_ROUND_BIT],
                                  state_q.ctrl[arss_pkg::CTRL_CLAMP_BIT]);
  end

  // Shifter: magnitude above 16 is limited so the barrel stays one cycle deep
  always_comb begin
    sh_right = !op.shift_amt[5];                                  // see RULE_20
    sh_mag   = sh_right ? op.shift_amt : 6'(-op.shift_amt);
    if (sh_mag > arss_pkg::SHIFT_LIMIT) begin
      sh_mag = arss_pkg::SHIFT_LIMIT;
    end
    if (op.kind == arss_pkg::OP_SHIFT_X) begin
      if (sh_right) begin
        sh_operand = {{8{op.shift_arith & op.x_data[15]}}, op.x_data, 16'h0000}; // see RULE_22
      end else begin
        sh_operand = {24'h000000, op.x_data};
      end
    end else begin
      sh_operand = op.target_b ? acc_b : acc_a;
    end
    if (sh_right && op.shift_arith) begin                         // see RULE_19
      sh_out = 40'($signed(sh_operand) >>> sh_mag);
    end else if (sh_right) begin
      sh_out = sh_operand >> sh_mag;
    end else begin
      sh_out = sh_operand << sh_mag;
    end
  end

  always_comb begin
    state_d          = state_q;
    state_d.xw.valid = 1'b0;
    state_d.sh.valid = 1'b0;
    state_d.trap     = 1'b0;
    state_d.rdata    = 16'h0000;

    if (reg_rd) begin
      case (reg_addr)
        arss_pkg::REG_CTRL:   state_d.rdata = {13'h0000, state_q.ctrl};
        arss_pkg::REG_STATUS: state_d.rdata = {14'h0000, state_q.limit};
        arss_pkg::REG_WBPTR:  state_d.rdata = state_q.wbptr;
        default:              state_d.rdata = 16'h0000;
      endcase
    end

    if (reg_wr) begin
      case (reg_addr)
        arss_pkg::REG_CTRL:   state_d.ctrl  = reg_wdata[2:0];
        arss_pkg::REG_STATUS: state_d.limit = state_q.limit & ~reg_wdata[1:0];
        arss_pkg::REG_WBPTR:  state_d.wbptr = reg_wdata;
        default:              state_d.ctrl  = state_d.ctrl;
      endcase
    end

    // Overflow set is applied after the clear so a same-cycle event is kept
    if (acc_a_ovf39) begin
      state_d.limit[arss_pkg::STAT_A_BIT] = 1'b1;                 // see RULE_01
    end
    if (acc_b_ovf39) begin
      state_d.limit[arss_pkg::STAT_B_BIT] = 1'b1;
    end
    if ((acc_a_ovf39 || acc_b_ovf39) && state_q.ctrl[arss_pkg::CTRL_TRAP_BIT]) begin
      state_d.trap = 1'b1;                                        // see RULE_02
    end

    if (op.valid) begin
      case (op.kind)
        arss_pkg::OP_STORE_TRUNC: begin
          state_d.xw = '{valid: 1'b1, addr: op.addr, data: store_trunc_word}; // see RULE_11
        end
        arss_pkg::OP_STORE_ROUND: begin
          state_d.xw = '{valid: 1'b1, addr: op.addr, data: store_round_word};
        end
        arss_pkg::OP_MAC_WB: begin
          // Core issues this kind only for accumulate ops that allow it   see RULE_03
          if (op.wb_mode == arss_pkg::WB_DIRECT) begin
            state_d.wbptr = wb_word;                              // see RULE_05
          end else begin
            state_d.xw    = '{valid: 1'b1, addr: state_q.wbptr, data: wb_word}; // see RULE_04, RULE_06
            state_d.wbptr = state_q.wbptr + arss_pkg::WBPTR_STEP; // see RULE_06
          end
        end
        arss_pkg::OP_SHIFT_ACC: begin
          state_d.sh = '{valid: 1'b1, acc: sh_out, word: sh_out[15:0]}; // see RULE_21
        end
        arss_pkg::OP_SHIFT_X: begin
          // General result comes from where the operand was placed
          state_d.sh = '{valid: 1'b1, acc: sh_out,
                         word: sh_right ? sh_out[31:16] : sh_out[15:0]}; // see RULE_21, RULE_22
        end
        default: begin
          state_d.sh.valid = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q       <= '0;
      state_q.ctrl  <= arss_pkg::CTRL_RESET;
      state_q.wbptr <= arss_pkg::WBPTR_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  assign reg_rdata                = state_q.rdata;
  assign xw                       = state_q.xw;
  assign shift_res                = state_q.sh;
  assign accum_a_limit_flag       = state_q.limit[arss_pkg::STAT_A_BIT];
  assign accum_b_limit_flag       = state_q.limit[arss_pkg::STAT_B_BIT];
  assign trap_req                 = state_q.trap;
  assign round_mode_select        = state_q.ctrl[arss_pkg::CTRL_ROUND_BIT];
  assign data_write_clamp_enable  = state_q.ctrl[arss_pkg::CTRL_CLAMP_BIT];
  assign catastrophic_trap_enable = state_q.ctrl[arss_pkg::CTRL_TRAP_BIT];
  assign writeback_pointer_reg    = state_q.wbptr;

endmodule : accum_round_saturate_shift

// ===== src/arss_pkg.sv
package arss_pkg;

  localparam int unsigned ACC_W   = 40;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned ADDR_W  = 16;
  localparam int unsigned REG_AW  = 4;
  localparam int unsigned SHAMT_W = 6;

  // Register indices on the plain register port
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_WBPTR  = 4'h2;

  // Control register fields
  localparam int unsigned CTRL_ROUND_BIT = 0;
  localparam int unsigned CTRL_CLAMP_BIT = 1;
  localparam int unsigned CTRL_TRAP_BIT  = 2;
  // Status register fields
  localparam int unsigned STAT_A_BIT     = 0;
  localparam int unsigned STAT_B_BIT     = 1;

  localparam logic [2:0]  CTRL_RESET  = 3'h0;
  localparam logic [15:0] WBPTR_RESET = 16'h0000;
  localparam logic [15:0] WBPTR_STEP  = 16'h0002;

  // Rounding and clamp figures
  localparam logic [15:0] LOW_HALF    = 16'h8000;
  localparam logic [24:0] POS_LIMIT   = 25'h0007FFF;
  localparam logic [24:0] NEG_LIMIT   = 25'h1FF8000;
  localparam logic [15:0] POS_CLAMP   = 16'h7FFF;
  localparam logic [15:0] NEG_CLAMP   = 16'h8000;
  localparam logic [5:0]  SHIFT_LIMIT = 6'h10;

  typedef enum logic [2:0] {
    OP_NONE        = 3'b000,
    OP_STORE_TRUNC = 3'b001,
    OP_STORE_ROUND = 3'b010,
    OP_MAC_WB      = 3'b011,
    OP_SHIFT_ACC   = 3'b100,
    OP_SHIFT_X     = 3'b101
  } op_kind_t;

  typedef enum logic {
    WB_DIRECT  = 1'b0,
    WB_POSTINC = 1'b1
  } wb_mode_t;

  typedef struct packed {
    logic              valid;
    op_kind_t          kind;
    logic              target_b;    // 1: accumulator B is the operation's target
    wb_mode_t          wb_mode;
    logic              shift_arith;
    logic [5:0]        shift_amt;   // Signed: positive right, negative left
    logic [15:0]       addr;
    logic [15:0]       x_data;
  } op_req_t;

  typedef struct packed {
    logic              valid;
    logic [15:0]       addr;
    logic [15:0]       data;
  } xwrite_t;

  typedef struct packed {
    logic              valid;
    logic [39:0]       acc;
    logic [15:0]       word;
  } shift_res_t;

  typedef struct packed {
    logic [2:0]        ctrl;
    logic [1:0]        limit;
    logic [15:0]       wbptr;
    logic [15:0]       rdata;
    logic              trap;
    xwrite_t           xw;
    shift_res_t        sh;
  } state_t;

endpackage : arss_pkg

// ===== verif/arss_core_model.sv
`timescale 1ns/10ps
module arss_core_model (
  input  wire logic        clk,
  output arss_pkg::op_req_t op,
  output logic [39:0]      acc_a,
  output logic [39:0]      acc_b,
  output logic             acc_a_ovf39,
  output logic             acc_b_ovf39
);
  initial begin
    op = '0;
    {acc_a, acc_b, acc_a_ovf39, acc_b_ovf39} = '0;
  end
  // Valid drops at the sampling edge; a caller may issue again right after it
  task automatic issue(input arss_pkg::op_req_t r, input logic [39:0] a, input logic [39:0] b);
    r.valid = 1'b1;
    op <= r;
    acc_a <= a;
    acc_b <= b;
    @(posedge clk);
    op.valid <= 1'b0;
  endtask : issue
  task automatic overflow(input logic on_b);
    acc_a_ovf39 <= !on_b;
    acc_b_ovf39 <= on_b;
    @(posedge clk);
    {acc_a_ovf39, acc_b_ovf39} <= 2'b00;
  endtask : overflow
endmodule : arss_core_model

// ===== verif/arss_monitor.sv
`timescale 1ns/10ps
module arss_monitor (
  input wire logic                 clk,
  input wire logic                 srst,
  input wire arss_pkg::op_req_t    op,
  input wire logic [39:0]          acc_a,
  input wire logic [39:0]          acc_b,
  input wire logic                 acc_a_ovf39,
  input wire logic                 acc_b_ovf39,
  input wire arss_pkg::xwrite_t    xw,
  input wire arss_pkg::shift_res_t shift_res,
  input wire logic                 accum_a_limit_flag,
  input wire logic                 trap_req,
  input wire logic                 data_write_clamp_enable,
  input wire logic                 catastrophic_trap_enable,
  input wire logic [15:0]          writeback_pointer_reg
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic [39:0] tgt;
  assign tgt = op.target_b ? acc_b : acc_a;
  sequence store_req;
    op.valid && op.kind inside {arss_pkg::OP_STORE_TRUNC, arss_pkg::OP_STORE_ROUND};
  endsequence
  sequence wb_req(m);
    op.valid && op.kind == arss_pkg::OP_MAC_WB && op.wb_mode == m;
  endsequence
  AST_FLAG_SET: assert property (acc_a_ovf39 |=> accum_a_limit_flag)
    else $error("limit flag not set");
  AST_TRAP_ON: assert property (acc_b_ovf39 && catastrophic_trap_enable |=> trap_req)
    else $error("trap missing");
  AST_TRAP_OFF: assert property (!catastrophic_trap_enable |=> !trap_req)
    else $error("trap while disabled");
  AST_STORE_ADDR: assert property (store_req |=> xw.valid && xw.addr == $past(op.addr))
    else $error("store not on X bus");
  AST_TRUNC: assert property (op.valid && op.kind == arss_pkg::OP_STORE_TRUNC
    && !data_write_clamp_enable |=> xw.data == $past(tgt[31:16]))
    else $error("truncated store wrong");
  AST_WB_POSTINC: assert property (wb_req(arss_pkg::WB_POSTINC) |=> xw.valid
    && xw.addr == $past(writeback_pointer_reg)
    && writeback_pointer_reg == $past(writeback_pointer_reg) + 16'h0002)
    else $error("post-increment write-back wrong");
  AST_WB_DIRECT: assert property (wb_req(arss_pkg::WB_DIRECT) |=> !xw.valid)
    else $error("direct write-back used X bus");
  AST_SHIFT_ZERO: assert property (op.valid && op.kind == arss_pkg::OP_SHIFT_ACC
    && op.shift_amt == 6'h00 |=> shift_res.valid && shift_res.acc == $past(tgt))
    else $error("zero shift altered operand");
endmodule : arss_monitor

bind accum_round_saturate_shift arss_monitor u_arss_monitor (
  .clk, .srst, .op, .acc_a, .acc_b, .acc_a_ovf39, .acc_b_ovf39, .xw, .shift_res,
  .accum_a_limit_flag, .trap_req, .data_write_clamp_enable, .catastrophic_trap_enable,
  .writeback_pointer_reg
);

// ===== verif/tb.sv
`timescale 1ns/10ps
module tb;
  logic                 clk = 1'b0;
  logic                 srst = 1'b1;
  logic [3:0]           reg_addr = 4'h0;
  logic [15:0]          reg_wdata = 16'h0000;
  logic                 reg_wr = 1'b0;
  logic                 reg_rd = 1'b0;
  logic [15:0]          reg_rdata, wbptr;
  arss_pkg::op_req_t    op;
  logic [39:0]          acc_a, acc_b;
  logic                 ovf_a, ovf_b, flag_a, flag_b, trap_req, rnd_sel, clamp_en, trap_en;
  arss_pkg::xwrite_t    xw;
  arss_pkg::shift_res_t shift_res;
  logic [2:0]           ctrl_v = 3'h0;
  int                   num_errors = 0;
  int                   checks_done = 0;
  logic [39:0] corner [9] = '{40'h00_1234_8000, 40'h00_1235_8000, 40'h00_1234_7FFF,
    40'h00_1234_FFFF, 40'h00_7FFF_8000, 40'h01_0000_0000, 40'hFE_0000_0000,
    40'hFF_8000_0000, 40'hFF_7FFF_FFFF};
  always #5 clk = ~clk;
  accum_round_saturate_shift u_accum_round_saturate_shift (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op(op), .acc_a(acc_a), .acc_b(acc_b),
    .acc_a_ovf39(ovf_a), .acc_b_ovf39(ovf_b), .xw(xw), .shift_res(shift_res),
    .accum_a_limit_flag(flag_a), .accum_b_limit_flag(flag_b), .trap_req(trap_req),
    .round_mode_select(rnd_sel), .data_write_clamp_enable(clamp_en),
    .catastrophic_trap_enable(trap_en), .writeback_pointer_reg(wbptr));
  arss_core_model u_arss_core_model (.clk(clk), .op(op), .acc_a(acc_a), .acc_b(acc_b),
    .acc_a_ovf39(ovf_a), .acc_b_ovf39(ovf_b));
  task automatic check(input logic [39:0] seen, input logic [39:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge clk);
    reg_wr <= 1'b0;
    #1;
  endtask : reg_write
  task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask : reg_read
  function automatic logic [15:0] exp_store(input logic [39:0] a, input logic rnd,
                                            input logic [2:0] c);
    logic        inc;
    logic [24:0] v;
    inc = rnd && a[15] && (a[14:0] != 15'h0 || !c[0] || a[16]);
    v = {a[39], a[39:16]} + {24'h0, inc};
    return (c[1] && !a[39] && v > 25'h0007FFF) ? 16'h7FFF
         : (c[1] && a[39] && v[24] && v < 25'h1FF8000) ? 16'h8000 : v[15:0];
  endfunction : exp_store
  function automatic logic [39:0] exp_shift(input logic [39:0] s, input logic [5:0] amt,
                                            input logic arith);
    logic [5:0] m;
    m = amt[5] ? 6'h00 - amt : amt;
    return amt[5] ? s << m : (arith ? 40'($signed(s) >>> m) : s >> m);
  endfunction : exp_shift
  task automatic run_op(input arss_pkg::op_req_t r, input logic [39:0] a, input logic [39:0] b);
    logic [39:0] t, n, s;
    logic [15:0] p, x;
    t = r.target_b ? b : a;
    n = r.target_b ? a : b;
    p = wbptr;
    x = r.x_data;
    u_arss_core_model.issue(r, a, b);
    #1;
    if (r.kind == arss_pkg::OP_MAC_WB) begin
      check(xw.valid, r.wb_mode);
      if (r.wb_mode == arss_pkg::WB_POSTINC) begin
        check({xw.addr, xw.data}, {p, exp_store(n, 1'b1, ctrl_v)});
        check(wbptr, p + 16'h0002);
      end else begin
        check(wbptr, exp_store(n, 1'b1, ctrl_v));
      end
    end else if (r.kind == arss_pkg::OP_SHIFT_ACC) begin
      s = exp_shift(t, r.shift_amt, r.shift_arith);
      check({shift_res.valid, shift_res.acc}, {1'b1, s});
      check(shift_res.word, s[15:0]);
    end else if (r.kind == arss_pkg::OP_SHIFT_X) begin
      s = exp_shift(r.shift_amt[5] ? {24'h0, x} : {r.shift_arith ? {8{x[15]}} : 8'h00, x,
          16'h0}, r.shift_amt, r.shift_arith);
      check(shift_res.word, r.shift_amt[5] ? s[15:0] : s[31:16]);
      check({shift_res.valid, xw.valid}, 2'b10);
    end else begin
      check({xw.valid, xw.addr}, {1'b1, r.addr});
      check(xw.data, exp_store(t, r.kind == arss_pkg::OP_STORE_ROUND, ctrl_v));
    end
  endtask : run_op
  task automatic print_verdict();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : print_verdict
  initial begin
    #200000;
    num_errors++;
    print_verdict();
  end
  initial begin
    arss_pkg::op_req_t r;
    logic [39:0]       a, b;
    void'($urandom(44));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 reg_write(4'hF, 16'hFFFF);
    reg_read(arss_pkg::REG_CTRL, 16'h0000);
    reg_read(4'hF, 16'h0000);
    u_arss_core_model.overflow(1'b0);
    #1 check({flag_a, flag_b, trap_req}, 3'b100);
    reg_write(arss_pkg::REG_CTRL, 16'h0004);
    check({trap_en, clamp_en, rnd_sel}, 3'b100);
    u_arss_core_model.overflow(1'b1);
    #1 check({flag_b, trap_req}, 2'b11);
    reg_read(arss_pkg::REG_STATUS, 16'h0003);
    reg_write(arss_pkg::REG_STATUS, 16'h0001);
    reg_read(arss_pkg::REG_STATUS, 16'h0002);
    for (int i = 0; i < 400; i++) begin
      if (i % 25 == 0) begin
        ctrl_v = {1'b0, 2'(i / 25)};
        reg_write(arss_pkg::REG_CTRL, {13'h0, ctrl_v});
        check({trap_en, clamp_en, rnd_sel}, ctrl_v);
        reg_write(arss_pkg::REG_WBPTR, 16'($urandom) & 16'hFFFE);
      end
      r = '0;
      r.kind = arss_pkg::op_kind_t'(3'(i % 5 + 1));
      {r.target_b, r.shift_arith, r.addr, r.x_data} = 34'({$urandom, $urandom});
      r.wb_mode = arss_pkg::wb_mode_t'(1'($urandom));
      r.shift_amt = (i % 3 == 0) ? 6'h00 : 6'($urandom_range(32) - 16);
      a = (i % 3 == 0) ? corner[(i / 3) % 9] : 40'({$urandom, $urandom});
      b = (i % 3 == 0) ? corner[(i / 3 + 4) % 9] : 40'({$urandom, $urandom});
      run_op(r, a, b);
    end
    print_verdict();
  end
endmodule : tb
